// ### core/wsd_pkg.sv
package wsd_pkg;

  // ----------------------------------------------------------------
  // Widths and source positions
  // ----------------------------------------------------------------
  localparam int unsigned DB_W    = 6;
  localparam int unsigned SRC_N   = 3;
  localparam int unsigned SRC_CMP = 0;
  localparam int unsigned SRC_LC2 = 1;
  localparam int unsigned SRC_FLT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic            FORCE_RST = 1'b0;
  localparam logic            OUT_RST   = 1'b0;
  localparam logic [DB_W-1:0] CNT_RST   = '0;
  localparam logic [2:0]      SYNC_RST  = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             gen_en;
    logic             auto_restart;
    logic [SRC_N-1:0] src_en;
    logic             ovr_a;
    logic             ovr_b;
    logic             pol_a;
    logic             pol_b;
    logic [DB_W-1:0]  db_rise;
    logic [DB_W-1:0]  db_fall;
  } wsd_cfg_t;

  typedef struct packed {
    logic out_a;
    logic out_b;
  } wsd_drive_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RISE_DB,
    ST_A_ON,
    ST_FALL_DB,
    ST_B_ON
  } wsd_state_t;

endpackage

// ### core/wsd_waveform_auto_shutdown.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Software force bit enters shutdown and drives override levels.
// - Without auto-restart, shutdown holds while the force bit is set.
// - With auto-restart, hardware clears force bit on next input rise.
// - Enabled comparator or logic cell forces override levels at once; fault pin only after its synchroniser and filter.
// - Comparator, logic cell and fault pin enable in any mix.
// - External sources act by level, not edge.
// - Active enabled source blocks leaving shutdown until it goes inactive or is disabled.
// - Dead-band delay varies by at most one generator clock.
// - Unsynchronised comparator output serves as shutdown source.
module wsd_waveform_auto_shutdown
  import wsd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire wsd_cfg_t   i_cfg,
  input  wire logic       i_force_set,
  input  wire logic       i_force_clr,
  input  wire logic       i_wave_in,
  input  wire logic       i_comparator_async_out,
  input  wire logic       i_logic_cell2_out,
  input  wire logic       i_fault_input_pin_n,
  output logic            o_shutdown_force_bit,
  output logic            o_source_active,
  output wsd_drive_t      o_drive
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Pin synchronisers with agreement filter
  // ----------------------------------------------------------------
  logic [2:0] wave_s_q;
  logic [2:0] wave_s_d;
  logic [2:0] flt_s_q;
  logic [2:0] flt_s_d;
  logic       wave_f_q;
  logic       wave_f_d;
  logic       wave_p_q;
  logic       wave_p_d;
  logic       flt_f_q;
  logic       flt_f_d;
  logic       wave_rise;

  // Agreement flop costs a cycle but drops one-sample glitches
  always_comb begin
    wave_s_d = {wave_s_q[1:0], i_wave_in};
    flt_s_d  = {flt_s_q[1:0], ~i_fault_input_pin_n};
    wave_f_d = wave_f_q;
    flt_f_d  = flt_f_q;
    if (wave_s_q[1] == wave_s_q[2]) begin
      wave_f_d = wave_s_q[2];
    end
    if (flt_s_q[1] == flt_s_q[2]) begin
      flt_f_d = flt_s_q[2];
    end
    wave_p_d = wave_f_q;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_s_q <= SYNC_RST;
      flt_s_q  <= SYNC_RST;
      wave_f_q <= 1'b0;
      flt_f_q  <= 1'b0;
      wave_p_q <= 1'b0;
    end else if (i_ce) begin
      wave_s_q <= wave_s_d;
      flt_s_q  <= flt_s_d;
      wave_f_q <= wave_f_d;
      flt_f_q  <= flt_f_d;
      wave_p_q <= wave_p_d;
    end
  end

  assign wave_rise = wave_f_q & ~wave_p_q;

  // ----------------------------------------------------------------
  // Shutdown state
  // ----------------------------------------------------------------
  logic             force_q;
  logic             force_d;
  logic             src_q;
  logic             src_d;
  logic [SRC_N-1:0] src_lvl;
  logic             src_act;
  logic             clr_req;

  always_comb begin
    src_lvl          = '0;
    // Comparator read raw for the fastest trip; metastability
    // risk on this path is accepted on purpose
    src_lvl[SRC_CMP] = i_comparator_async_out;
    src_lvl[SRC_LC2] = i_logic_cell2_out;
    src_lvl[SRC_FLT] = flt_f_q;
    src_act = |(src_lvl & i_cfg.src_en);
    clr_req = (i_force_clr | (i_cfg.auto_restart & wave_rise))
              & ~src_act;
    force_d = force_q;
    if (i_force_set || src_act) begin
      force_d = 1'b1;
    end else if (clr_req) begin
      force_d = 1'b0;
    end
    src_d = src_act;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_q <= FORCE_RST;
      src_q   <= 1'b0;
    end else if (i_ce) begin
      force_q <= force_d;
      src_q   <= src_d;
    end
  end

  // ----------------------------------------------------------------
  // Dead-band generator
  // ----------------------------------------------------------------
  wsd_state_t      st_q;
  wsd_state_t      st_d;
  logic [DB_W-1:0] cnt_q;
  logic [DB_W-1:0] cnt_d;

  // Counter loads one less than the setting: the entry edge counts
  function automatic logic [DB_W-1:0] dec_cnt(input logic [DB_W-1:0] v);
    dec_cnt = (v == '0) ? v : v - 1'b1;
  endfunction

  always_comb begin
    st_d  = st_q;
    cnt_d = dec_cnt(cnt_q);
    if (!i_cfg.gen_en) begin
      st_d  = ST_OFF;
      cnt_d = CNT_RST;
    end else begin
      unique case (st_q)
        ST_OFF, ST_B_ON, ST_FALL_DB: begin
          if (wave_f_q) begin
            st_d  = (i_cfg.db_rise == '0) ? ST_A_ON : ST_RISE_DB;
            cnt_d = dec_cnt(i_cfg.db_rise);
          end else if (st_q == ST_OFF) begin
            st_d  = ST_B_ON;
          end else if (st_q == ST_FALL_DB && cnt_q == '0) begin
            st_d  = ST_B_ON;
          end
        end
        ST_RISE_DB, ST_A_ON: begin
          if (!wave_f_q) begin
            st_d  = (i_cfg.db_fall == '0) ? ST_B_ON : ST_FALL_DB;
            cnt_d = dec_cnt(i_cfg.db_fall);
          end else if (st_q == ST_RISE_DB && cnt_q == '0) begin
            st_d  = ST_A_ON;
          end
        end
        // Illegal code falls back to idle
        default: begin
          st_d  = ST_OFF;
          cnt_d = CNT_RST;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_OFF;
      cnt_q <= CNT_RST;
    end else if (i_ce) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Output drive with override
  // ----------------------------------------------------------------
  wsd_drive_t drv_q;
  wsd_drive_t drv_d;

  always_comb begin
    drv_d.out_a = ((st_q == ST_A_ON) & i_cfg.gen_en) ^ i_cfg.pol_a;
    drv_d.out_b = ((st_q == ST_B_ON) & i_cfg.gen_en) ^ i_cfg.pol_b;
    // Next force value, so a trip reaches the pins in one edge
    if (force_d) begin
      drv_d.out_a = i_cfg.ovr_a;
      drv_d.out_b = i_cfg.ovr_b;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_q <= '{out_a: OUT_RST, out_b: OUT_RST};
    end else if (i_ce) begin
      drv_q <= drv_d;
    end
  end

  assign o_drive              = drv_q;
  assign o_shutdown_force_bit = force_q;
  assign o_source_active      = src_q;

endmodule
`default_nettype wire

// ### testbench/wsd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wsd_asserts
  import wsd_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_ce,
  input wire wsd_cfg_t   i_cfg,
  input wire logic       i_force_set,
  input wire logic       i_force_clr,
  input wire logic       i_comparator_async_out,
  input wire logic       i_logic_cell2_out,
  input wire logic       i_fault_input_pin_n,
  input wire logic       o_shutdown_force_bit,
  input wire logic       o_source_active,
  input wire wsd_drive_t o_drive
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_FORCE: assert property (
    i_ce && i_force_set |=> o_shutdown_force_bit)
    else $error("force set ignored");
  AST_OVR: assert property (
    o_shutdown_force_bit |-> o_drive == {i_cfg.ovr_a, i_cfg.ovr_b})
    else $error("override levels wrong");
  AST_HOLD: assert property (
    i_ce && o_shutdown_force_bit && !i_force_clr && !i_cfg.auto_restart
    |=> o_shutdown_force_bit)
    else $error("shutdown dropped");
  AST_CLR: assert property (
    i_ce && i_force_clr && !i_force_set && i_cfg.src_en == 3'h0
    |=> !o_shutdown_force_bit)
    else $error("clear ignored");
  AST_CMP: assert property (
    i_ce && i_cfg.src_en[SRC_CMP] && i_comparator_async_out
    |=> o_shutdown_force_bit)
    else $error("comparator shutdown late");
  AST_LEVEL: assert property (
    (i_ce && i_cfg.src_en[SRC_LC2] && i_logic_cell2_out) [*2]
    |=> o_source_active)
    else $error("source level not seen");
  AST_STUCK: assert property (
    o_shutdown_force_bit && i_ce
    && |(i_cfg.src_en[1:0] & {i_logic_cell2_out, i_comparator_async_out})
    |=> o_shutdown_force_bit)
    else $error("left shutdown with source active");
  AST_FLT: assert property (
    $fell(i_fault_input_pin_n) && i_ce && i_cfg.src_en[SRC_FLT]
    |-> ##[1:6] o_shutdown_force_bit)
    else $error("fault shutdown late");
endmodule
bind wsd_waveform_auto_shutdown wsd_asserts u_chk (.i_clk, .i_rst_n, .i_ce,
  .i_cfg, .i_force_set, .i_force_clr, .i_comparator_async_out,
  .i_logic_cell2_out, .i_fault_input_pin_n, .o_shutdown_force_bit,
  .o_source_active, .o_drive);
`default_nettype wire

// ### testbench/wsd_stage.sv
`timescale 1ns/1ps
`default_nettype none
module wsd_stage
  import wsd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire wsd_drive_t i_drive,
  output logic [7:0]      o_shoot
);
  // Counts cycles with both switches on
  initial o_shoot = 8'h00;
  always @(posedge i_clk) begin
    if (i_drive.out_a && i_drive.out_b) o_shoot <= o_shoot + 8'h01;
  end
endmodule
`default_nettype wire

// ### testbench/wsd_waveform_auto_shutdown_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module wsd_waveform_auto_shutdown_bench
  import wsd_pkg::*;
;
  logic       clk, rst_n, ce, fs, fc, wv, cmp, lc, flt_n, fb, sa;
  wsd_cfg_t   cfg;
  wsd_drive_t drv;
  logic [7:0] shoot;
  int         err_total, n_compared;
  wsd_waveform_auto_shutdown dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_cfg(cfg), .i_force_set(fs), .i_force_clr(fc), .i_wave_in(wv),
    .i_comparator_async_out(cmp), .i_logic_cell2_out(lc),
    .i_fault_input_pin_n(flt_n), .o_shutdown_force_bit(fb),
    .o_source_active(sa), .o_drive(drv));
  wsd_stage u_stage (.i_clk(clk), .i_drive(drv), .o_shoot(shoot));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task lim(input bit hit);
    if (hit) begin
      err_total++;
      test_done;
    end
  endtask
  task wt(input logic v);
    for (int i = 0; i < 12 && fb !== v; i++) cyc(1);
    lim(fb !== v);
  endtask
  task t_dead(input logic up);
    int n;
    wv = up;
    for (n = 0; n < 12 && (up ? drv.out_b : drv.out_a) !== 1'b0; n++) cyc(1);
    lim(n == 12);
    for (n = 0; n < 70 && (up ? drv.out_a : drv.out_b) !== 1'b1; n++) cyc(1);
    lim(n == 70);
    `CHK(n, int'(up ? cfg.db_rise : cfg.db_fall))
    $display("test dead band done");
  endtask
  task t_soft;
    fs = 1'b1;
    cyc(1);
    fs = 1'b0;
    `CHK(drv, {cfg.ovr_a, cfg.ovr_b})
    cyc(5);
    `CHK(fb, 1'b1)
    fc = 1'b1;
    cyc(1);
    fc = 1'b0;
    `CHK(fb, 1'b0)
    $display("test soft done");
  endtask
  task t_auto;
    cfg.auto_restart = 1'b1;
    wv = 1'b0;
    fs = 1'b1;
    cyc(1);
    fs = 1'b0;
    cyc(5);
    `CHK(fb, 1'b1)
    wv = 1'b1;
    wt(1'b0);
    `CHK(fb, 1'b0)
    `CHK(drv == {cfg.ovr_a, cfg.ovr_b}, 1'b0)
    cfg.auto_restart = 1'b0;
    $display("test auto done");
  endtask
  task t_src;
    for (int k = 0; k < 3; k++) begin
      cfg.src_en = 3'h1 << k;
      {cmp, lc, flt_n} = {k == 0, k == 1, k != 2};
      wt(1'b1);
      fc = 1'b1;
      cyc(3);
      `CHK({fb, sa}, 2'h3)
      {cmp, lc, flt_n} = 3'h1;
      cyc(7);
      cyc(1);
      `CHK(fb, 1'b0)
      fc = 1'b0;
    end
    cfg.src_en = 3'h0;
    $display("test sources done");
  endtask
  task t_freeze;
    ce = 1'b0;
    fs = 1'b1;
    cyc(3);
    `CHK(fb, 1'b0)
    ce = 1'b1;
    cyc(1);
    fs = 1'b0;
    `CHK(fb, 1'b1)
    fc = 1'b1;
    cyc(1);
    fc = 1'b0;
    `CHK(fb, 1'b0)
    $display("test clock enable done");
  endtask
  initial begin
    {rst_n, fs, fc, wv, cmp, lc} = 6'h00;
    flt_n = 1'b1;
    ce = 1'b1;
    cfg = '{gen_en: 1'b1, ovr_a: 1'b1, db_rise: 6'h04, db_fall: 6'h03,
      default: '0};
    cyc(2);
    rst_n = 1'b1;
    cyc(8);
    t_dead(1'b1);
    t_soft;
    t_auto;
    t_src;
    t_freeze;
    t_dead(1'b0);
    `CHK(shoot, 8'h00)
    test_done;
  end
endmodule
`default_nettype wire
